// ### pkg/cttd_pkg.sv
// Purpose: constants and types for the test/transfer decode core
// Assumes: 8-bit data, 16-bit addresses, single clock
// Notes: opcodes outside the test/transfer group are local choices
package cttd_pkg;
	typedef logic [7:0]  cttd_byte_t;
	typedef logic [15:0] cttd_word_t;

	// prefix selects the stack-relative form
	localparam cttd_byte_t OPC_PREFIX       = 8'h9E;
	localparam cttd_byte_t OPC_TEST_DIR     = 8'h3D;
	localparam cttd_byte_t OPC_TEST_ACC     = 8'h4D;
	localparam cttd_byte_t OPC_TEST_IDXLO   = 8'h5D;
	localparam cttd_byte_t OPC_TEST_IX1     = 8'h6D;
	localparam cttd_byte_t OPC_TEST_IX      = 8'h7D;
	localparam cttd_byte_t OPC_SP_TO_INDEX  = 8'h95;
	localparam cttd_byte_t OPC_IDXLO_TO_ACC = 8'h9F;
	localparam cttd_byte_t OPC_INDEX_TO_SP  = 8'h94;
	// mode carriers for the remaining addressing forms
	localparam cttd_byte_t OPC_LOAD_EXT     = 8'hC6;
	localparam cttd_byte_t OPC_LOAD_IX2     = 8'hD6;
	localparam cttd_byte_t OPC_MOVE_DIXP    = 8'h5E;
	localparam cttd_byte_t OPC_MOVE_IXPD    = 8'h7E;
	localparam cttd_byte_t OPC_CMPBR_DIR    = 8'h31;
	localparam cttd_byte_t OPC_CMPBR_IX1P   = 8'h61;

	localparam int FLG_V = 7;
	localparam int FLG_H = 4;
	localparam int FLG_I = 3;
	localparam int FLG_N = 2;
	localparam int FLG_Z = 1;
	localparam int FLG_C = 0;

	localparam cttd_byte_t FLAGS_RESET = 8'h68;
	localparam cttd_word_t PC_RESET    = 16'h0000;
	localparam cttd_word_t SP_RESET    = 16'h00FF;
	localparam cttd_word_t IDX_RESET   = 16'h0000;
	localparam cttd_byte_t ACC_RESET   = 8'h00;
	localparam cttd_byte_t ZERO8       = 8'h00;
	localparam cttd_byte_t DIRECT_PAGE = 8'h00;
	localparam cttd_word_t ONE16       = 16'h0001;

	typedef enum logic [2:0] {
		op_none, op_test_neg_zero, op_sp_to_index_xfer, op_idxlo_to_acc_xfer,
		op_index_to_sp_xfer, op_load_acc, op_move, op_cmp_branch
	} cttd_op_t;

	typedef enum logic [3:0] {
		md_inh, md_acc, md_idxlo, md_dir, md_ext, md_idx_none, md_idx_short,
		md_idx_long, md_stk_short, md_stk_long, md_idx_short_postinc,
		md_dir_to_idx_postinc, md_idx_postinc_to_dir
	} cttd_mode_t;

	typedef enum logic [2:0] {st_fetch, st_opnd, st_read, st_write, st_xfer} cttd_state_t;
endpackage : cttd_pkg

// ### src/cttd_core.sv
// Purpose: decode/execute core for test and transfer instructions
// Assumes: memory answers mem_rdata in the same cycle as mem_rd
// Notes: unknown opcodes execute as one-cycle no-ops
// Function
// - test subtracts zero, clears V, sets N Z
// - test opcodes map to their addressing modes
// - sp-to-index loads sp plus one, two cycles
// - index low to accumulator, one cycle
// - index-to-sp loads index minus one, two cycles
// - prefix byte selects stack-relative instruction form
// - stack short mode: sp plus unsigned byte
// - stack long mode: sp plus two-byte offset
// - indexed long mode: index plus offset, high first
// - extended mode: address high byte then low
// - indexed short postinc: index plus byte, increment
// - direct-to-indexed move, then index incremented
// - indexed-to-direct move, then index incremented
// - branch test: direct byte then relative offset
`timescale 1ns/1ps
module cttd_core (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// memory bus
	output logic              mem_rd,
	output logic              mem_wr,
	output cttd_pkg::cttd_word_t mem_addr,
	output cttd_pkg::cttd_byte_t mem_wdata,
	input  wire cttd_pkg::cttd_byte_t mem_rdata,
	// processor state
	output cttd_pkg::cttd_byte_t acc,
	output cttd_pkg::cttd_word_t idx,
	output cttd_pkg::cttd_word_t sp,
	output cttd_pkg::cttd_word_t pc,
	output cttd_pkg::cttd_byte_t condition_flags,
	output logic              instr_done
);
	import cttd_pkg::*;

	cttd_state_t state, next_state;
	cttd_op_t    op, next_op, dec_op;
	cttd_mode_t  mode, next_mode, dec_mode;
	logic        pre, next_pre;
	logic [1:0]  cnt, next_cnt;
	cttd_byte_t  b1, next_b1, b2, next_b2, data, next_data, next_acc, next_flags;
	cttd_word_t  next_idx, next_sp, next_pc, src_addr, dst_addr;

	function automatic logic [1:0] op_len(cttd_op_t o, cttd_mode_t m);
		logic [1:0] n;
		unique case (m)
			md_ext, md_idx_long, md_stk_long:   n = 2'd2;
			md_inh, md_acc, md_idxlo, md_idx_none: n = 2'd0;
			default:                             n = 2'd1;
		endcase
		if (o == op_cmp_branch)
			n = n + 2'd1;
		return n;
	endfunction : op_len

	// operand minus zero; V forced clear, H I C untouched
	function automatic cttd_byte_t nz_flags(cttd_byte_t f, cttd_byte_t r);
		cttd_byte_t res;
		res = r - ZERO8;
		f[FLG_V] = 1'b0;
		f[FLG_N] = res[7];
		f[FLG_Z] = (res == ZERO8);
		return f;
	endfunction : nz_flags

	// decode of the byte on the bus, qualified by the prefix
	always_comb begin
		dec_op = op_none;
		dec_mode = md_inh;
		unique case ({pre, mem_rdata})
			{1'b0, OPC_TEST_DIR}: begin
				dec_op = op_test_neg_zero;
				dec_mode = md_dir;
			end
			{1'b0, OPC_TEST_ACC}: begin
				dec_op = op_test_neg_zero;
				dec_mode = md_acc;
			end
			{1'b0, OPC_TEST_IDXLO}: begin
				dec_op = op_test_neg_zero;
				dec_mode = md_idxlo;
			end
			{1'b0, OPC_TEST_IX1}: begin
				dec_op = op_test_neg_zero;
				dec_mode = md_idx_short;
			end
			{1'b0, OPC_TEST_IX}: begin
				dec_op = op_test_neg_zero;
				dec_mode = md_idx_none;
			end
			{1'b1, OPC_TEST_IX1}: begin
				dec_op = op_test_neg_zero;
				dec_mode = md_stk_short;
			end
			{1'b0, OPC_SP_TO_INDEX}:  dec_op = op_sp_to_index_xfer;
			{1'b0, OPC_IDXLO_TO_ACC}: dec_op = op_idxlo_to_acc_xfer;
			{1'b0, OPC_INDEX_TO_SP}:  dec_op = op_index_to_sp_xfer;
			{1'b0, OPC_LOAD_EXT}: begin
				dec_op = op_load_acc;
				dec_mode = md_ext;
			end
			{1'b0, OPC_LOAD_IX2}: begin
				dec_op = op_load_acc;
				dec_mode = md_idx_long;
			end
			{1'b1, OPC_LOAD_IX2}: begin
				dec_op = op_load_acc;
				dec_mode = md_stk_long;
			end
			{1'b0, OPC_MOVE_DIXP}: begin
				dec_op = op_move;
				dec_mode = md_dir_to_idx_postinc;
			end
			{1'b0, OPC_MOVE_IXPD}: begin
				dec_op = op_move;
				dec_mode = md_idx_postinc_to_dir;
			end
			{1'b0, OPC_CMPBR_DIR}: begin
				dec_op = op_cmp_branch;
				dec_mode = md_dir;
			end
			{1'b0, OPC_CMPBR_IX1P}: begin
				dec_op = op_cmp_branch;
				dec_mode = md_idx_short_postinc;
			end
			default: dec_op = op_none;
		endcase
	end

	// effective addresses from the collected operand bytes
	always_comb begin
		unique case (mode)
			md_ext:       src_addr = {b1, b2};
			md_idx_none,
			md_idx_postinc_to_dir: src_addr = idx;
			md_idx_short,
			md_idx_short_postinc:  src_addr = idx + {ZERO8, b1};
			md_idx_long:  src_addr = idx + {b1, b2};
			md_stk_short: src_addr = sp + {ZERO8, b1};
			md_stk_long:  src_addr = sp + {b1, b2};
			default:      src_addr = {DIRECT_PAGE, b1};
		endcase
		dst_addr = (mode == md_dir_to_idx_postinc) ? idx : {DIRECT_PAGE, b1};
	end

	always_comb begin
		next_state = state;
		next_op = op;
		next_mode = mode;
		next_pre = pre;
		next_cnt = cnt;
		next_b1 = b1;
		next_b2 = b2;
		next_data = data;
		next_acc = acc;
		next_idx = idx;
		next_sp = sp;
		next_pc = pc;
		next_flags = condition_flags;
		mem_rd = 1'b0;
		mem_wr = 1'b0;
		mem_addr = pc;
		instr_done = 1'b0;
		unique case (state)
			st_fetch: begin
				mem_rd = 1'b1;
				next_pc = pc + ONE16;
				if (!pre && mem_rdata == OPC_PREFIX) begin
					next_pre = 1'b1;
				end else begin
					next_pre = 1'b0;
					next_op = dec_op;
					next_mode = dec_mode;
					next_cnt = 2'd0;
					if (dec_op == op_test_neg_zero && dec_mode == md_acc) begin
						next_flags = nz_flags(condition_flags, acc);
						instr_done = 1'b1;
					end else if (dec_op == op_test_neg_zero && dec_mode == md_idxlo) begin
						next_flags = nz_flags(condition_flags, idx[7:0]);
						instr_done = 1'b1;
					end else if (dec_op == op_idxlo_to_acc_xfer) begin
						next_acc = idx[7:0];
						instr_done = 1'b1;
					end else if (dec_op == op_none) begin
						instr_done = 1'b1;
					end else if (dec_op == op_sp_to_index_xfer || dec_op == op_index_to_sp_xfer) begin
						next_state = st_xfer;
					end else if (op_len(dec_op, dec_mode) != 2'd0) begin
						next_state = st_opnd;
					end else begin
						next_state = st_read;
					end
				end
			end
			st_opnd: begin
				mem_rd = 1'b1;
				next_pc = pc + ONE16;
				// first byte is the high half of any two-byte field
				if (cnt == 2'd0)
					next_b1 = mem_rdata;
				else
					next_b2 = mem_rdata;
				next_cnt = cnt + 2'd1;
				if (cnt + 2'd1 == op_len(op, mode))
					next_state = st_read;
			end
			st_read: begin
				mem_rd = 1'b1;
				mem_addr = src_addr;
				next_state = st_fetch;
				instr_done = 1'b1;
				unique case (op)
					op_test_neg_zero: next_flags = nz_flags(condition_flags, mem_rdata);
					op_load_acc: begin
						next_acc = mem_rdata;
						next_flags = nz_flags(condition_flags, mem_rdata);
					end
					op_move: begin
						next_data = mem_rdata;
						next_state = st_write;
						instr_done = 1'b0;
					end
					op_cmp_branch: begin
						// pc already points past the whole instruction
						if (acc == mem_rdata)
							next_pc = pc + {{8{b2[7]}}, b2};
						if (mode == md_idx_short_postinc)
							next_idx = idx + ONE16;
					end
					default: next_state = st_fetch;
				endcase
			end
			st_write: begin
				mem_wr = 1'b1;
				mem_addr = dst_addr;
				next_flags = nz_flags(condition_flags, data);
				next_idx = idx + ONE16;
				next_state = st_fetch;
				instr_done = 1'b1;
			end
			st_xfer: begin
				if (op == op_sp_to_index_xfer)
					next_idx = sp + ONE16;
				else
					next_sp = idx - ONE16;
				next_state = st_fetch;
				instr_done = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= st_fetch;
			op <= op_none;
			mode <= md_inh;
			pre <= 1'b0;
			cnt <= 2'd0;
			b1 <= ZERO8;
			b2 <= ZERO8;
			data <= ZERO8;
			acc <= ACC_RESET;
			idx <= IDX_RESET;
			sp <= SP_RESET;
			pc <= PC_RESET;
			condition_flags <= FLAGS_RESET;
		end else begin
			state <= next_state;
			op <= next_op;
			mode <= next_mode;
			pre <= next_pre;
			cnt <= next_cnt;
			b1 <= next_b1;
			b2 <= next_b2;
			data <= next_data;
			acc <= next_acc;
			idx <= next_idx;
			sp <= next_sp;
			pc <= next_pc;
			condition_flags <= next_flags;
		end
	end

	assign mem_wdata = data;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic fetch_op;
	assign fetch_op = state == st_fetch && !pre && mem_rdata != OPC_PREFIX;

	test_flags_a: assert property (state == st_read && op == op_test_neg_zero |=>
		!condition_flags[FLG_V] && condition_flags[FLG_N] == $past(mem_rdata[7])
		&& condition_flags[FLG_Z] == ($past(mem_rdata) == ZERO8)
		&& condition_flags[FLG_C] == $past(condition_flags[FLG_C])
		&& condition_flags[FLG_H] == $past(condition_flags[FLG_H]))
		else $error("test flags wrong");
	test_decode_a: assert property (fetch_op && mem_rdata == OPC_TEST_DIR |=>
		op == op_test_neg_zero && mode == md_dir && state == st_opnd)
		else $error("test decode wrong");
	sp_index_a: assert property (fetch_op && mem_rdata == OPC_SP_TO_INDEX |=>
		state == st_xfer && instr_done ##1 idx == $past(sp) + ONE16
		&& condition_flags == $past(condition_flags, 2))
		else $error("sp to index wrong");
	idx_acc_a: assert property (fetch_op && mem_rdata == OPC_IDXLO_TO_ACC |->
		instr_done ##1 acc == $past(idx[7:0]) && state == st_fetch
		&& condition_flags == $past(condition_flags))
		else $error("index to acc wrong");
	index_sp_a: assert property (fetch_op && mem_rdata == OPC_INDEX_TO_SP |=>
		##1 sp == $past(idx, 2) - ONE16 && condition_flags == $past(condition_flags, 2))
		else $error("index to sp wrong");
	prefix_sel_a: assert property (state == st_fetch && !pre && mem_rdata == OPC_PREFIX
		##1 mem_rdata == OPC_TEST_IX1 |=> mode == md_stk_short ##1 state == st_read)
		else $error("prefix form wrong");
	stack_addr_a: assert property (state == st_read && mode == md_stk_long |->
		mem_addr == sp + {$past(mem_rdata, 2), $past(mem_rdata)})
		else $error("stack long address wrong");
	postinc_a: assert property (state == st_read && mode == md_idx_short_postinc |=>
		idx == $past(idx) + ONE16)
		else $error("postinc missing");
	move_write_a: assert property (state == st_read && op == op_move |=>
		mem_wr && mem_wdata == $past(mem_rdata) ##1 idx == $past(idx) + ONE16)
		else $error("move write wrong");
	branch_pc_a: assert property (state == st_read && op == op_cmp_branch
		&& acc == mem_rdata |=> pc == $past(pc) + {{8{$past(b2[7])}}, $past(b2)})
		else $error("branch target wrong");

	cov_stack_test_c: cover property (state == st_read && mode == md_stk_short);
	cov_sp_index_c: cover property (state == st_xfer && op == op_sp_to_index_xfer);
	cov_move_c: cover property (state == st_write && mode == md_idx_postinc_to_dir);
	cov_branch_c: cover property (state == st_read && op == op_cmp_branch && acc == mem_rdata);
endmodule : cttd_core

// ### sim/cttd_mem_model.sv
// Purpose: zero-wait byte memory on the far side of the core bus
// Assumes: read answers in the same cycle, write lands on the rising edge
// Notes: with no read strobe the bus shows the inverted last byte, not a copy
`timescale 1ns/1ps
module cttd_mem_model (
	// clock
	input  wire logic                 clk,
	// memory bus
	input  wire logic                 mem_rd,
	input  wire logic                 mem_wr,
	input  wire cttd_pkg::cttd_word_t mem_addr,
	input  wire cttd_pkg::cttd_byte_t mem_wdata,
	output cttd_pkg::cttd_byte_t      mem_rdata
);
	import cttd_pkg::*;

	cttd_byte_t mem [0:65535];
	cttd_byte_t last;

	initial begin
		last = 8'h00;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
		end
	end

	// idle bus must not look like a valid answer
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;

	always @(posedge clk) begin
		if (mem_rd) begin
			last <= mem[mem_addr];
		end
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
	end
endmodule : cttd_mem_model

// ### sim/cttd_core_tb_top.sv
// Purpose: self-checking runs of test and transfer programs
// Assumes: each instruction is written to memory just before it executes
// Notes: cycle counts checked only where they are fixed
`timescale 1ns/1ps
module cttd_core_tb_top;
	import cttd_pkg::*;

	logic       clk;
	logic       rst_n;
	logic       mem_rd;
	logic       mem_wr;
	logic       instr_done;
	cttd_word_t mem_addr;
	cttd_word_t idx;
	cttd_word_t sp;
	cttd_word_t pc;
	cttd_byte_t mem_wdata;
	cttd_byte_t mem_rdata;
	cttd_byte_t acc;
	cttd_byte_t condition_flags;
	int         errors;
	int         checked;
	logic [31:0] seed;
	cttd_byte_t img [0:65535];
	cttd_byte_t e_acc;
	cttd_byte_t e_fl;
	cttd_word_t e_idx;
	cttd_word_t e_sp;
	cttd_word_t e_pc;
	cttd_word_t pa;
	cttd_word_t a;
	cttd_word_t w;
	cttd_byte_t d;

	initial clk = 1'b0;
	always #5 clk = ~clk;

	cttd_core i_dut (.clk(clk), .rst_n(rst_n), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .acc(acc),
		.idx(idx), .sp(sp), .pc(pc), .condition_flags(condition_flags),
		.instr_done(instr_done));

	cttd_mem_model i_mem (.clk(clk), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function cttd_byte_t rb();
		logic [31:0] r;
		r = rnd();
		return r[7:0];
	endfunction : rb

	function automatic cttd_byte_t nz(input cttd_byte_t f, input cttd_byte_t v);
		cttd_byte_t r;
		r = f;
		r[FLG_V] = 1'b0;
		r[FLG_N] = v[7];
		r[FLG_Z] = (v == ZERO8);
		return r;
	endfunction : nz

	task automatic wrap_up();
		if (errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic chk_val(input cttd_word_t got, input cttd_word_t exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_cyc(input int got, input int exp);
		checked++;
		if (got != exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_cyc

	task automatic state();
		chk_val({8'h00, acc}, {8'h00, e_acc});
		chk_val(idx, e_idx);
		chk_val(sp, e_sp);
		chk_val(pc, e_pc);
		chk_val({8'h00, condition_flags}, {8'h00, e_fl});
	endtask : state

	task automatic poke(input cttd_word_t ad, input cttd_byte_t v);
		img[ad] = v;
		i_mem.mem[ad] = v;
	endtask : poke

	// memory is combinational, so bytes poked at c0 are seen at the next edge
	task automatic op(input int n, input logic [31:0] v);
		pa = e_pc;
		for (int k = 0; k < n; k++) begin
			poke(pa, v[31 - 8 * k -: 8]);
			pa = pa + ONE16;
		end
	endtask : op

	task automatic fl(input cttd_byte_t v);
		e_fl = nz(e_fl, v);
		e_pc = pa;
	endtask : fl

	task automatic load(input cttd_word_t ad);
		e_acc = img[ad];
		fl(e_acc);
	endtask : load

	task automatic step(input int cyc);
		int n;
		n = 1;
		// let the freshly poked opcode reach the decoder before looking
		#1;
		while (instr_done !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (instr_done !== 1'b1) begin
			errors++;
			wrap_up();
		end
		@(negedge clk);
		if (cyc != 0) begin
			chk_cyc(n, cyc);
		end
		state();
	endtask : step

	initial begin
		seed = 32'h6AFB6BED;
		errors = 0;
		checked = 0;
		rst_n = 1'b0;
		for (int it = 0; it < 2; it++) begin
			rst_n = 1'b0;
			// fill only after the model's start-up zeroing is over
			repeat (8) @(negedge clk);
			for (int i = 16'h40; i < 16'h400; i++) begin
				poke(i[15:0], rb());
			end
			for (int i = 0; i < 256; i++) begin
				poke({8'h40, i[7:0]}, rb());
			end
			e_acc = ACC_RESET;
			e_idx = IDX_RESET;
			e_sp = SP_RESET;
			e_pc = PC_RESET;
			e_fl = FLAGS_RESET;
			state();
			rst_n = 1'b1;
			a = {8'h40, rb()};
			poke(a, rb() | 8'h80);
			op(3, {OPC_LOAD_EXT, a, 8'h00});
			load(a);
			step(0);
			op(1, {OPC_SP_TO_INDEX, 24'h000000});
			e_idx = e_sp + ONE16;
			e_pc = pa;
			step(2);
			op(1, {OPC_IDXLO_TO_ACC, 24'h000000});
			e_acc = e_idx[7:0];
			e_pc = pa;
			step(1);
			op(1, {OPC_TEST_ACC, 24'h000000});
			fl(e_acc);
			step(1);
			d = rb() | 8'h40;
			op(2, {OPC_TEST_DIR, d, 16'h0000});
			fl(img[{DIRECT_PAGE, d}]);
			step(3);
			op(1, {OPC_TEST_IDXLO, 24'h000000});
			fl(e_idx[7:0]);
			step(1);
			op(1, {OPC_TEST_IX, 24'h000000});
			fl(img[e_idx]);
			step(2);
			d = rb();
			op(2, {OPC_TEST_IX1, d, 16'h0000});
			fl(img[e_idx + {8'h00, d}]);
			step(3);
			op(3, {OPC_PREFIX, OPC_TEST_IX1, d, 8'h00});
			fl(img[e_sp + {8'h00, d}]);
			step(4);
			w = {8'h01, rb()};
			op(3, {OPC_LOAD_IX2, w, 8'h00});
			load(e_idx + w);
			step(0);
			w = {8'h02, rb()};
			op(4, {OPC_PREFIX, OPC_LOAD_IX2, w});
			load(e_sp + w);
			step(0);
			d = rb() | 8'h40;
			op(2, {OPC_MOVE_DIXP, d, 16'h0000});
			a = e_idx;
			img[a] = img[{DIRECT_PAGE, d}];
			fl(img[a]);
			e_idx = e_idx + ONE16;
			step(0);
			chk_val({8'h00, i_mem.mem[a]}, {8'h00, img[a]});
			d = rb() | 8'h80;
			op(2, {OPC_MOVE_IXPD, d, 16'h0000});
			a = {DIRECT_PAGE, d};
			img[a] = img[e_idx];
			fl(img[a]);
			e_idx = e_idx + ONE16;
			step(0);
			chk_val({8'h00, i_mem.mem[a]}, {8'h00, img[a]});
			op(1, {OPC_INDEX_TO_SP, 24'h000000});
			e_sp = e_idx - ONE16;
			e_pc = pa;
			step(2);
			// short forward hop keeps the program clear of the data area
			d = rb();
			w = {8'h00, rb() & 8'h07};
			poke(e_idx + {8'h00, d}, e_acc);
			op(3, {OPC_CMPBR_IX1P, d, w[7:0], 8'h00});
			e_pc = pa + w;
			e_idx = e_idx + ONE16;
			step(0);
			d = 8'h40 | (rb() & 8'h1F);
			poke({DIRECT_PAGE, d}, ~e_acc);
			op(3, {OPC_CMPBR_DIR, d, rb(), 8'h00});
			e_pc = pa;
			step(0);
			d = d ^ 8'h20;
			poke({DIRECT_PAGE, d}, e_acc);
			op(3, {OPC_CMPBR_DIR, d, 16'h8000});
			e_pc = pa - 16'h0080;
			step(0);
		end
		wrap_up();
	end
endmodule : cttd_core_tb_top
